// ---- design/bbmau_pkg.sv ----
// Constants and types of the broadband MAU control block
package bbmau_pkg;

  // **************************************************
  // Timing
  // **************************************************
  localparam int CLK_NS = 10;
  localparam int BIT_NS = 100;
  localparam int BIT_CYC = BIT_NS / CLK_NS;
  localparam logic [3:0] DIV_LAST = 4'(BIT_CYC - 1);
  localparam int BITS_PER_MS = 1000000 / BIT_NS;
  localparam int TIMEOUT1_MS = 25;
  localparam int TIMEOUT2_MS = 100;
  localparam logic [9:0] CED_WIN_BITS = 10'h1c2;
  localparam logic [5:0] UMD_TMO_BITS = 6'h20;
  localparam logic [7:0] BBBW_BITS = 8'h8f;
  localparam logic [4:0] GATE_DLY = 5'h0a;
  localparam logic [4:0] GATE_END = 5'h14;
  localparam logic [4:0] SQE_TEST_BITS = 5'h18;
  localparam logic [7:0] UMD_PAT = 8'h5e;

  // **************************************************
  // Register map
  // **************************************************
  localparam logic [11:0] ADDR_CTRL = 12'h000;
  localparam logic [11:0] ADDR_STAT = 12'h004;
  localparam logic [11:0] ADDR_CCNT = 12'h008;
  localparam int CTRL_PDIS = 0;
  localparam logic CTRL_PDIS_RST = 1'h0;
  localparam int STAT_SQE = 0;
  localparam int STAT_RX = 1;
  localparam int STAT_DDRV = 2;
  localparam int STAT_CDRV = 3;
  localparam int STAT_MS = 4;
  localparam int STAT_JB = 8;

  // **************************************************
  // Types
  // **************************************************
  typedef enum logic [2:0] {
    MS_IDLE = 3'h0,
    MS_TX = 3'h1,
    MS_SQE = 3'h3,
    MS_COLL = 3'h5,
    MS_RX = 3'h4
  } bbmau_ms_t;

  typedef enum logic [1:0] {
    JB_IDLE = 2'h0,
    JB_INT = 2'h1,
    JB_JAB = 2'h3
  } bbmau_jb_t;

  // Serial bit with valid: valid low means IDL
  typedef struct packed {
    logic valid;
    logic bit_v;
  } bbmau_bit_t;

  typedef struct packed {
    logic psel;
    logic penable;
    logic pwrite;
    logic [11:0] paddr;
    logic [31:0] pwdata;
  } bbmau_apb_req_t;

  typedef struct packed {
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
  } bbmau_apb_rsp_t;

endpackage

// ---- design/bbmau_core.sv ----
// Broadband MAU collision, SQE and jabber control with APB registers
//
// Register access over APB and the register addresses are this design's own decisions.
`timescale 1ns/1ps
`default_nettype none

module bbmau_core #(
  parameter logic [19:0] T1_BITS =
    20'(bbmau_pkg::TIMEOUT1_MS * bbmau_pkg::BITS_PER_MS),
  parameter logic [19:0] T2_BITS =
    20'(bbmau_pkg::TIMEOUT2_MS * bbmau_pkg::BITS_PER_MS)
) (
  // Clock and reset
  input wire logic clock,
  input wire logic resetn,
  // APB slave
  input wire bbmau_pkg::bbmau_apb_req_t apb_req,
  output bbmau_pkg::bbmau_apb_rsp_t apb_rsp,
  // AUI side
  input wire bbmau_pkg::bbmau_bit_t dte_do,
  output bbmau_pkg::bbmau_bit_t dte_di,
  output logic ci_sqe,
  // Receive path from demodulator
  input wire logic rf_data_band,
  input wire logic rf_ce_band,
  input wire logic rx_scr_bit,
  input wire bbmau_pkg::bbmau_bit_t rx_in,
  // Transmit path
  input wire logic tx_scr_bit,
  output logic data_drv_en,
  output logic ce_drv_en
);
  import bbmau_pkg::*;

  // **************************************************
  // Bit clock enable
  // **************************************************
  logic [3:0] div_r;
  logic bit_en;

  always_ff @(posedge clock) begin
    if (!resetn || div_r == DIV_LAST) begin
      div_r <= 4'h0;
    end else begin
      div_r <= div_r + 4'h1;
    end
  end

  assign bit_en = (div_r == DIV_LAST);

  // **************************************************
  // Receive energy and windows
  // **************************************************
  logic rx_energy;
  logic rxe_q_r;
  logic dband_q_r;
  logic [9:0] cw_cnt_r;
  logic ced_window;
  bbmau_ms_t ms_r;
  bbmau_ms_t ms_nxt;
  bbmau_jb_t jb_r;

  assign rx_energy = rf_data_band | rf_ce_band;

  always_ff @(posedge clock) begin
    if (!resetn) begin
      rxe_q_r <= 1'h0;
      dband_q_r <= 1'h0;
    end else begin
      rxe_q_r <= rx_energy;
      dband_q_r <= rf_data_band;
    end
  end

  always_ff @(posedge clock) begin
    if (!resetn) begin
      cw_cnt_r <= 10'h000;
    end else if (rx_energy && !rxe_q_r) begin
      cw_cnt_r <= CED_WIN_BITS;
    end else if (bit_en && cw_cnt_r != 10'h000) begin
      cw_cnt_r <= cw_cnt_r - 10'h001;
    end
  end

  assign ced_window = (cw_cnt_r != 10'h000);

  // **************************************************
  // UMD detection and timeout
  // **************************************************
  logic [7:0] tx_sh_r;
  logic [7:0] rx_sh_r;
  logic tx_found_r;
  logic rx_found_r;
  logic tx_umd;
  logic rx_umd;
  logic [5:0] ut_cnt_r;
  logic ut_arm_r;
  logic umd_exp;

  assign tx_umd = bit_en && dte_do.valid && !tx_found_r &&
    ({tx_sh_r[6:0], tx_scr_bit} == UMD_PAT);
  assign rx_umd = bit_en && rf_data_band && !rx_found_r &&
    ({rx_sh_r[6:0], rx_scr_bit} == UMD_PAT);

  always_ff @(posedge clock) begin
    if (!resetn) begin
      tx_sh_r <= 8'h00;
      tx_found_r <= 1'h0;
    end else if (!dte_do.valid) begin
      tx_sh_r <= 8'h00;
      tx_found_r <= 1'h0;
    end else if (bit_en) begin
      tx_sh_r <= {tx_sh_r[6:0], tx_scr_bit};
      tx_found_r <= tx_found_r | tx_umd;
    end
  end

  always_ff @(posedge clock) begin
    if (!resetn) begin
      rx_sh_r <= 8'h00;
      rx_found_r <= 1'h0;
    end else if (!rf_data_band) begin
      rx_sh_r <= 8'h00;
      rx_found_r <= 1'h0;
    end else if (bit_en) begin
      rx_sh_r <= {rx_sh_r[6:0], rx_scr_bit};
      rx_found_r <= rx_found_r | rx_umd;
    end
  end

  always_ff @(posedge clock) begin
    if (!resetn || !rf_data_band) begin
      ut_cnt_r <= 6'h00;
      ut_arm_r <= 1'h0;
    end else if (!dband_q_r) begin
      ut_cnt_r <= UMD_TMO_BITS;
      ut_arm_r <= 1'h1;
    end else if (rx_umd) begin
      ut_arm_r <= 1'h0;
    end else if (bit_en && ut_cnt_r != 6'h00) begin
      ut_cnt_r <= ut_cnt_r - 6'h01;
    end
  end

  assign umd_exp = ut_arm_r && (ut_cnt_r == 6'h00);

  // **************************************************
  // Bit-by-bit compare
  // **************************************************
  logic tx_mem [0:255];
  logic [7:0] tw_idx_r;
  logic [7:0] rc_idx_r;
  logic bbbw_r;
  logic ne_r;

  always_ff @(posedge clock) begin
    if (!resetn || tx_umd) begin
      tw_idx_r <= 8'h00;
    end else if (bit_en && tx_found_r && dte_do.valid &&
                 tw_idx_r < BBBW_BITS) begin
      tx_mem[tw_idx_r] <= tx_scr_bit;
      tw_idx_r <= tw_idx_r + 8'h01;
    end
  end

  always_ff @(posedge clock) begin
    if (!resetn || !rf_data_band) begin
      bbbw_r <= 1'h0;
      rc_idx_r <= 8'h00;
    end else if (rx_umd) begin
      bbbw_r <= 1'h1;
      rc_idx_r <= 8'h00;
    end else if (bit_en && bbbw_r) begin
      bbbw_r <= (rc_idx_r != BBBW_BITS - 8'h01);
      rc_idx_r <= rc_idx_r + 8'h01;
    end
  end

  // mismatch flag, held clear while the state machine is idle
  always_ff @(posedge clock) begin
    if (!resetn || ms_r == MS_IDLE) begin
      ne_r <= 1'h0;
    end else if (bit_en && bbbw_r && ms_r == MS_TX &&
                 tx_mem[rc_idx_r] != rx_scr_bit) begin
      ne_r <= 1'h1;
    end
  end

  // **************************************************
  // Receive data to DI and SQE test gate
  // **************************************************
  logic rx_r;
  logic [4:0] gate_cnt_r;
  logic ced_gate;
  logic [4:0] st_cnt_r;
  logic sqe_timer;

  always_ff @(posedge clock) begin
    if (!resetn) begin
      dte_di <= '0;
      rx_r <= 1'h0;
    end else begin
      dte_di.valid <= rx_in.valid;
      dte_di.bit_v <= rx_in.valid & rx_in.bit_v;
      rx_r <= rx_in.valid;
    end
  end

  // gate timed from the last DI bit
  always_ff @(posedge clock) begin
    if (!resetn) begin
      gate_cnt_r <= GATE_END;
    end else if (rx_r && !rx_in.valid) begin
      gate_cnt_r <= 5'h00;
    end else if (bit_en && gate_cnt_r != GATE_END) begin
      gate_cnt_r <= gate_cnt_r + 5'h01;
    end
  end

  assign ced_gate = (gate_cnt_r >= GATE_DLY) && (gate_cnt_r < GATE_END);

  always_ff @(posedge clock) begin
    if (!resetn) begin
      st_cnt_r <= 5'h00;
    end else if (ms_r == MS_TX && ms_nxt == MS_SQE) begin
      st_cnt_r <= SQE_TEST_BITS;
    end else if (bit_en && st_cnt_r != 5'h00) begin
      st_cnt_r <= st_cnt_r - 5'h01;
    end
  end

  assign sqe_timer = (st_cnt_r != 5'h00);

  // **************************************************
  // Main state machine
  // **************************************************
  logic coll_det;

  assign coll_det = ne_r | umd_exp | rf_ce_band;

  always_comb begin
    ms_nxt = ms_r;
    case (ms_r)
      MS_IDLE: begin
        if (dte_do.valid) begin
          ms_nxt = rx_energy ? MS_COLL : MS_TX;
        end else if (rx_energy) begin
          ms_nxt = MS_RX;
        end
      end
      MS_RX: begin
        if (dte_do.valid) begin
          ms_nxt = MS_COLL;
        end else if (!rx_energy) begin
          ms_nxt = MS_IDLE;
        end
      end
      MS_TX: begin
        if (coll_det) begin
          ms_nxt = MS_COLL;
        end else if (!dte_do.valid) begin
          ms_nxt = MS_SQE;
        end
      end
      MS_SQE: begin
        if (!sqe_timer && !rf_ce_band) begin
          ms_nxt = MS_IDLE;
        end
      end
      MS_COLL: begin
        if (!dte_do.valid && !rx_energy) begin
          ms_nxt = MS_IDLE;
        end
      end
      default: ms_nxt = MS_IDLE;
    endcase
  end

  always_ff @(posedge clock) begin
    if (!resetn) begin
      ms_r <= MS_IDLE;
    end else begin
      ms_r <= ms_nxt;
    end
  end

  // **************************************************
  // Jabber timers and state machine
  // **************************************************
  logic [19:0] ft_cnt_r;
  logic [19:0] jt_cnt_r;
  logic tx_energy;

  // Intended RF output, ahead of the jabber gate
  assign tx_energy = (ms_r == MS_TX) ||
    (ms_r == MS_COLL && dte_do.valid) || (ms_r == MS_SQE && sqe_timer);

  always_ff @(posedge clock) begin
    if (!resetn || !dte_do.valid) begin
      ft_cnt_r <= 20'h00000;
    end else if (bit_en && ft_cnt_r != T1_BITS) begin
      ft_cnt_r <= ft_cnt_r + 20'h00001;
    end
  end

  always_ff @(posedge clock) begin
    if (!resetn || !tx_energy) begin
      jt_cnt_r <= 20'h00000;
    end else if (bit_en && jt_cnt_r != T2_BITS) begin
      jt_cnt_r <= jt_cnt_r + 20'h00001;
    end
  end

  always_ff @(posedge clock) begin
    if (!resetn) begin
      jb_r <= JB_IDLE;
    end else begin
      case (jb_r)
        JB_IDLE: begin
          if (jt_cnt_r == T2_BITS) begin
            jb_r <= JB_JAB;
          end else if (ft_cnt_r == T1_BITS) begin
            jb_r <= JB_INT;
          end
        end
        JB_INT: begin
          if (jt_cnt_r == T2_BITS) begin
            jb_r <= JB_JAB;
          end else if (!dte_do.valid) begin
            jb_r <= JB_IDLE;
          end
        end
        JB_JAB: begin
          if (!dte_do.valid) begin
            jb_r <= JB_IDLE;
          end
        end
        default: jb_r <= JB_IDLE;
      endcase
    end
  end

  // **************************************************
  // Drivers and SQE
  // **************************************************
  logic ctrl_pdis_r;
  logic pos_disable;
  logic jb_ovr;
  logic want_ce;
  logic sqe_nxt;

  assign pos_disable = ctrl_pdis_r | (jb_r == JB_JAB);
  assign jb_ovr = (jb_r != JB_IDLE);
  // CE burst for the self test or enforcement
  assign want_ce = (ms_r == MS_COLL && dte_do.valid) ||
    (ms_r == MS_SQE && sqe_timer);

  always_ff @(posedge clock) begin
    if (!resetn) begin
      ce_drv_en <= 1'h0;
      data_drv_en <= 1'h0;
    end else begin
      ce_drv_en <= want_ce && !jb_ovr && !pos_disable;
      data_drv_en <= ms_r == MS_TX && !want_ce && !jb_ovr &&
        !pos_disable;
    end
  end

  assign sqe_nxt = (ms_r == MS_COLL && rx_energy) ||
    ((ms_r == MS_IDLE || ms_r == MS_RX) && rf_ce_band && ced_window) ||
    (ms_r == MS_SQE && rf_ce_band && ced_gate) || jb_ovr;

  // IDL on CI when no SQE
  always_ff @(posedge clock) begin
    if (!resetn) begin
      ci_sqe <= 1'h0;
    end else begin
      ci_sqe <= sqe_nxt;
    end
  end

  // **************************************************
  // APB registers
  // **************************************************
  logic [15:0] ccnt_r;
  logic [31:0] prdata_r;
  logic mapped;
  logic wr_ctrl;

  assign mapped = apb_req.paddr == ADDR_CTRL ||
    apb_req.paddr == ADDR_STAT || apb_req.paddr == ADDR_CCNT;
  assign wr_ctrl = apb_req.psel && apb_req.penable && apb_req.pwrite &&
    apb_req.paddr == ADDR_CTRL;

  always_ff @(posedge clock) begin
    if (!resetn) begin
      ctrl_pdis_r <= CTRL_PDIS_RST;
    end else if (wr_ctrl) begin
      ctrl_pdis_r <= apb_req.pwdata[CTRL_PDIS];
    end
  end

  always_ff @(posedge clock) begin
    if (!resetn) begin
      ccnt_r <= 16'h0000;
    end else if (ms_nxt == MS_COLL && ms_r != MS_COLL) begin
      ccnt_r <= ccnt_r + 16'h0001;
    end
  end

  // Read data captured in the setup phase
  always_ff @(posedge clock) begin
    if (!resetn) begin
      prdata_r <= 32'h00000000;
    end else if (apb_req.psel && !apb_req.penable) begin
      prdata_r <= 32'h00000000;
      case (apb_req.paddr)
        ADDR_CTRL: prdata_r[CTRL_PDIS] <= ctrl_pdis_r;
        ADDR_STAT: begin
          prdata_r[STAT_SQE] <= ci_sqe;
          prdata_r[STAT_RX] <= rx_r;
          prdata_r[STAT_DDRV] <= data_drv_en;
          prdata_r[STAT_CDRV] <= ce_drv_en;
          prdata_r[STAT_MS +: 3] <= ms_r;
          prdata_r[STAT_JB +: 2] <= jb_r;
        end
        ADDR_CCNT: prdata_r[15:0] <= ccnt_r;
        default: prdata_r <= 32'h00000000;
      endcase
    end
  end

  assign apb_rsp.prdata = prdata_r;
  assign apb_rsp.pready = 1'h1;
  assign apb_rsp.pslverr = apb_req.psel && apb_req.penable && !mapped;

  // **************************************************
  // Assertions
  // **************************************************
  default clocking cb @(posedge clock); endclocking
  default disable iff (!resetn);

  property p_excl;
    !(data_drv_en && ce_drv_en);
  endproperty
  a_excl: assert property (p_excl)
    else $error("data and CE drivers both on");

  property p_pdis;
    pos_disable |=> !data_drv_en && !ce_drv_en;
  endproperty
  a_pdis: assert property (p_pdis)
    else $error("driver on under positive disable");

  property p_jab;
    jb_r != JB_IDLE |=> ci_sqe && !data_drv_en;
  endproperty
  a_jab: assert property (p_jab)
    else $error("jabber did not override outputs");

  property p_di;
    rx_in.valid |=> dte_di.valid && dte_di.bit_v == $past(rx_in.bit_v);
  endproperty
  a_di: assert property (p_di)
    else $error("DI bit does not follow received bit");

  property p_idl;
    !rx_in.valid |=> !dte_di.valid;
  endproperty
  a_idl: assert property (p_idl)
    else $error("DI not idle without data");

  property p_cw;
    $rose(rx_energy) |=> ced_window && cw_cnt_r == CED_WIN_BITS;
  endproperty
  a_cw: assert property (p_cw)
    else $error("collision window did not open");

  property p_umd;
    ms_r == MS_TX && umd_exp |=> ms_r == MS_COLL ##1 ci_sqe || !rx_energy;
  endproperty
  a_umd: assert property (p_umd)
    else $error("UMD timeout gave no collision");

  property p_sqet;
    ms_r == MS_TX && ms_nxt == MS_SQE |=> st_cnt_r == SQE_TEST_BITS;
  endproperty
  a_sqet: assert property (p_sqet)
    else $error("SQE test timer not started");

  property p_solo;
    ms_r == MS_TX && !rx_energy && jb_r == JB_IDLE |=> !ci_sqe;
  endproperty
  a_solo: assert property (p_solo)
    else $error("SQE with no other sender");

  c_test: cover property (ms_r == MS_SQE && ci_sqe);
  c_coll: cover property (ms_r == MS_TX ##1 ms_r == MS_COLL);
  c_jab: cover property (jb_r == JB_INT);

endmodule

`default_nettype wire

// ---- tb/bbmau_dte_model.sv ----
// Behavioural DTE that sends frames on the DO circuit
`timescale 1ns/1ps
`default_nettype none

module bbmau_dte_model (
  // Clock and reset
  input wire logic clock,
  input wire logic resetn,
  // Frame request
  input wire logic go,
  input wire logic [9:0] nbits,
  output logic busy,
  // DO circuit
  output bbmau_pkg::bbmau_bit_t dte_do
);
  import bbmau_pkg::*;

  logic [3:0] div_r;
  logic [9:0] left_r;
  logic [9:0] sent_r;

  // **************************************************
  // Bit timing, aligned to the MAU divider
  // **************************************************
  always_ff @(posedge clock) begin
    if (!resetn) begin
      div_r <= 4'h0;
    end else if (div_r == DIV_LAST) begin
      div_r <= 4'h0;
    end else begin
      div_r <= div_r + 4'h1;
    end
  end

  // **************************************************
  // Frame output
  // **************************************************
  // CD bits then IDL
  always_ff @(posedge clock) begin
    if (!resetn) begin
      left_r <= 10'h000;
      sent_r <= 10'h000;
      dte_do <= '0;
    end else if (go) begin
      left_r <= nbits;
      sent_r <= 10'h000;
    end else if (div_r == DIV_LAST) begin
      if (left_r != 10'h000) begin
        left_r <= left_r - 10'h001;
        sent_r <= sent_r + 10'h001;
        dte_do.valid <= 1'b1;
        // Each frame opens with the delimiter, MSB first
        dte_do.bit_v <= (sent_r < 10'h008) ? UMD_PAT[~sent_r[2:0]] :
          sent_r[0] ^ sent_r[3];
      end else begin
        // Idle line drops valid and inverts the bit each bit time
        dte_do.valid <= 1'b0;
        dte_do.bit_v <= ~dte_do.bit_v;
      end
    end
  end

  assign busy = dte_do.valid | (left_r != 10'h000);

endmodule
`default_nettype wire

// ---- tb/bbmau_core_tb_top.sv ----
// Self-checking testbench of the broadband MAU control block
`timescale 1ns/1ps
`default_nettype none

module bbmau_core_tb_top;
  import bbmau_pkg::*;

  localparam logic [7:0] RX_PAT = 8'h96;

  logic clock;
  logic resetn;
  bbmau_apb_req_t apb_req;
  bbmau_apb_rsp_t apb_rsp;
  bbmau_bit_t dte_do;
  bbmau_bit_t dte_di;
  bbmau_bit_t rx_in;
  logic ci_sqe;
  logic rf_data_band;
  logic rf_ce_band;
  logic rx_scr_bit;
  logic tx_scr_bit;
  logic data_drv_en;
  logic ce_drv_en;
  logic go;
  logic [9:0] nbits;
  logic busy;
  logic lb_on;
  logic flip;
  logic [19:0] lb_r;
  logic [31:0] rd;
  logic err;
  int n_fail = 0;
  int checks = 0;
  int cyc = 0;

  // **************************************************
  // Instances
  // **************************************************
  bbmau_core #(.T1_BITS(20'h000c8), .T2_BITS(20'h00190)) u_dut (
    .clock(clock), .resetn(resetn), .apb_req(apb_req), .apb_rsp(apb_rsp),
    .dte_do(dte_do), .dte_di(dte_di), .ci_sqe(ci_sqe),
    .rf_data_band(rf_data_band), .rf_ce_band(rf_ce_band),
    .rx_scr_bit(rx_scr_bit), .rx_in(rx_in), .tx_scr_bit(tx_scr_bit),
    .data_drv_en(data_drv_en), .ce_drv_en(ce_drv_en)
  );

  bbmau_dte_model u_dte (
    .clock(clock), .resetn(resetn), .go(go), .nbits(nbits), .busy(busy),
    .dte_do(dte_do)
  );

  initial clock = 1'b0;
  always #5 clock = ~clock;

  always @(posedge clock) begin
    tx_scr_bit <= dte_do.bit_v;
    lb_r <= {lb_r[18:0], dte_do.bit_v};
    // Loopback echoes the transmit stream two bit times later
    rx_scr_bit <= lb_on ? lb_r[19] ^ flip : rx_in.bit_v;
  end

  // **************************************************
  // Tasks
  // **************************************************
  task automatic tick(input int n);
    repeat (n) @(posedge clock);
  endtask

  task automatic bits(input int n);
    tick(n * BIT_CYC);
  endtask

  task automatic check(input string name, input logic [31:0] seen,
                       input logic [31:0] exp);
    checks++;
    if (seen !== exp) begin
      n_fail++;
      $display("Error %s expected %h seen %h", name, exp, seen);
    end
  endtask

  task automatic apb(input logic wr, input logic [11:0] addr,
                     input logic [31:0] wdata);
    @(posedge clock);
    apb_req.psel <= 1'b1;
    apb_req.penable <= 1'b0;
    apb_req.pwrite <= wr;
    apb_req.paddr <= addr;
    apb_req.pwdata <= wdata;
    @(posedge clock);
    apb_req.penable <= 1'b1;
    @(posedge clock);
    while (apb_rsp.pready !== 1'b1) @(posedge clock);
    rd = apb_rsp.prdata;
    err = apb_rsp.pslverr;
    apb_req.psel <= 1'b0;
    apb_req.penable <= 1'b0;
  endtask

  task automatic rd_chk(input string name, input logic [11:0] addr,
                        input logic [31:0] exp);
    apb(1'b0, addr, 32'h0);
    check(name, rd, exp);
  endtask

  task automatic send(input logic [9:0] n);
    @(posedge clock);
    go <= 1'b1;
    nbits <= n;
    @(posedge clock);
    go <= 1'b0;
    while (dte_do.valid !== 1'b1) @(posedge clock);
  endtask

  task automatic wait_idle;
    while (busy !== 1'b0) @(posedge clock);
  endtask

  task automatic test_done;
    if (n_fail == 0 && checks > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask

  always @(posedge clock) begin
    cyc <= cyc + 1;
    if (cyc == 30000) begin
      n_fail++;
      test_done;
    end
  end

  // **************************************************
  // Test sequence
  // **************************************************
  initial begin
    apb_req = '0;
    rx_in = '0;
    rf_data_band = 1'b0;
    rf_ce_band = 1'b0;
    lb_on = 1'b0;
    flip = 1'b0;
    go = 1'b0;
    nbits = 10'h000;
    resetn = 1'b0;
    tick(4);
    resetn <= 1'b1;
    @(negedge clock);
    check("ci_sqe", {31'h0, ci_sqe}, 32'h0);
    check("drivers", {30'h0, data_drv_en, ce_drv_en}, 32'h0);
    check("dte_di", {30'h0, dte_di}, 32'h0);
    rd_chk("stat", ADDR_STAT, 32'h0);
    rd_chk("ctrl", ADDR_CTRL, 32'h0);
    rd_chk("unmapped", 12'h00c, 32'h0);
    check("pslverr", {31'h0, err}, 32'h1);
    apb(1'b1, ADDR_STAT, 32'hffffffff);
    rd_chk("stat ro", ADDR_STAT, 32'h0);
    // Reception, then CE power inside the window
    rf_data_band <= 1'b1;
    for (int i = 0; i < 8; i++) begin
      @(posedge clock);
      rx_in <= {1'b1, RX_PAT[i]};
      @(posedge clock);
      @(negedge clock);
      check("dte_di", {30'h0, dte_di}, {30'h0, 1'b1, RX_PAT[i]});
    end
    rd_chk("stat rx", ADDR_STAT, 32'h00000042);
    check("ci_sqe", {31'h0, ci_sqe}, 32'h0);
    rf_ce_band <= 1'b1;
    tick(3);
    @(negedge clock);
    check("ci_sqe", {31'h0, ci_sqe}, 32'h1);
    @(posedge clock);
    rf_ce_band <= 1'b0;
    rf_data_band <= 1'b0;
    rx_in <= '0;
    tick(3);
    @(negedge clock);
    check("dte_di", {30'h0, dte_di}, 32'h0);
    check("ci_sqe", {31'h0, ci_sqe}, 32'h0);
    bits(8);
    // Clean transmission and SQE test
    send(10'h040);
    tick(3);
    @(negedge clock);
    check("drivers", {30'h0, data_drv_en, ce_drv_en}, 32'h2);
    rd_chk("stat tx", ADDR_STAT, 32'h00000014);
    rx_in.valid <= 1'b1;
    wait_idle;
    rx_in.valid <= 1'b0;
    tick(3);
    @(negedge clock);
    check("drivers", {30'h0, data_drv_en, ce_drv_en}, 32'h1);
    bits(10);
    rf_ce_band <= 1'b1;
    bits(4);
    @(negedge clock);
    check("ci_sqe", {31'h0, ci_sqe}, 32'h1);
    @(posedge clock);
    rf_ce_band <= 1'b0;
    tick(3);
    @(negedge clock);
    check("ci_sqe", {31'h0, ci_sqe}, 32'h0);
    bits(12);
    @(negedge clock);
    check("drivers", {30'h0, data_drv_en, ce_drv_en}, 32'h0);
    // Other station during transmission
    send(10'h040);
    bits(4);
    rf_ce_band <= 1'b1;
    tick(3);
    @(negedge clock);
    check("ci_sqe", {31'h0, ci_sqe}, 32'h1);
    check("drivers", {30'h0, data_drv_en, ce_drv_en}, 32'h1);
    rd_chk("stat coll", ADDR_STAT, 32'h00000059);
    @(posedge clock);
    rf_ce_band <= 1'b0;
    wait_idle;
    bits(4);
    // Data RF without a receive delimiter
    send(10'h040);
    bits(2);
    rf_data_band <= 1'b1;
    bits(28);
    rd_chk("stat umd", ADDR_STAT, 32'h00000014);
    bits(6);
    apb(1'b0, ADDR_STAT, 32'h0);
    check("umd state", {29'h0, rd[6:4]}, 32'h5);
    @(posedge clock);
    rf_data_band <= 1'b0;
    wait_idle;
    bits(4);
    rd_chk("ccnt", ADDR_CCNT, 32'h2);
    // Looped-back stream, then inverted bits
    send(10'h040);
    rf_data_band <= 1'b1;
    lb_on <= 1'b1;
    bits(40);
    rd_chk("stat cmp", ADDR_STAT, 32'h00000014);
    flip <= 1'b1;
    bits(2);
    rd_chk("stat ne", ADDR_STAT, 32'h00000059);
    @(posedge clock);
    rf_data_band <= 1'b0;
    lb_on <= 1'b0;
    flip <= 1'b0;
    wait_idle;
    bits(4);
    // Positive disable
    apb(1'b1, ADDR_CTRL, 32'hffffffff);
    rd_chk("ctrl", ADDR_CTRL, 32'h1);
    send(10'h020);
    bits(8);
    @(negedge clock);
    check("drivers", {30'h0, data_drv_en, ce_drv_en}, 32'h0);
    wait_idle;
    bits(30);
    @(negedge clock);
    check("drivers", {30'h0, data_drv_en, ce_drv_en}, 32'h0);
    apb(1'b1, ADDR_CTRL, 32'h0);
    // Overlong transmission
    send(10'h1f4);
    bits(150);
    @(negedge clock);
    check("drivers", {30'h0, data_drv_en, ce_drv_en}, 32'h2);
    bits(300);
    @(negedge clock);
    check("drivers", {30'h0, data_drv_en, ce_drv_en}, 32'h0);
    check("ci_sqe", {31'h0, ci_sqe}, 32'h1);
    apb(1'b0, ADDR_STAT, 32'h0);
    check("jabber", {30'h0, rd[9:8]}, 32'h3);
    wait_idle;
    bits(30);
    @(negedge clock);
    check("ci_sqe", {31'h0, ci_sqe}, 32'h0);
    apb(1'b0, ADDR_STAT, 32'h0);
    check("jabber", {30'h0, rd[9:8]}, 32'h0);
    test_done;
  end

endmodule
`default_nettype wire
